/* logic/psm_pkg.sv */
// Shared constants and types for position scaling and line function map.
// Assumes one system clock and a word-wide parameter access port.
package psm_pkg;

    // Parameter addresses
    localparam logic [15:0] OFF_SCALE_DEN = 16'h060e;
    localparam logic [15:0] OFF_SCALE_NUM = 16'h0610;
    localparam logic [15:0] OFF_LINE_FN_BASE = 16'h0722;
    localparam logic [15:0] OFF_LINE_FN_STEP = 16'h0002;
    localparam logic [15:0] OFF_LINE_STATE = 16'h0730;
    localparam logic [15:0] OFF_FREE_OUT = 16'h0732;

    // Factory values and limits
    localparam logic [31:0] SCALE_NUM_RST = 32'h0000_0001;
    localparam logic [31:0] SCALE_DEN_RST = 32'h0000_4000;
    localparam logic [31:0] SCALE_MIN = 32'h0000_0001;
    localparam logic [31:0] SCALE_MAX = 32'h7fff_ffff;
    localparam int INC_SHIFT = 15;
    localparam logic [31:0] INC_PER_REV = 32'h0000_8000;
    localparam logic [31:0] RANGE_MIN = 32'hc000_0000;
    localparam logic [31:0] RANGE_MAX = 32'h3fff_ffff;
    localparam logic [31:0] SAT_POS = 32'h7fff_ffff;
    localparam logic [31:0] SAT_NEG = 32'h8000_0000;

    // Line function codes
    localparam logic [15:0] FN_FREE_IN = 16'h0001;
    localparam logic [15:0] FN_FAULT_RESET = 16'h0002;
    localparam logic [15:0] FN_ENABLE = 16'h0003;
    localparam logic [15:0] FN_HALT = 16'h0004;
    localparam logic [15:0] FN_JOG_POS = 16'h0009;
    localparam logic [15:0] FN_JOG_NEG = 16'h000a;
    localparam logic [15:0] FN_JOG_FAST = 16'h000b;
    localparam logic [15:0] FN_REF_SW = 16'h0014;
    localparam logic [15:0] FN_LIM_POS = 16'h0015;
    localparam logic [15:0] FN_LIM_NEG = 16'h0016;
    localparam logic [15:0] FN_OUT_FREE = 16'h0065;
    localparam logic [15:0] FN_OUT_NO_FAULT = 16'h0066;
    localparam logic [15:0] FN_OUT_ACTIVE = 16'h0067;

    // Factory line map, listed from line four down to line one
    localparam logic [3:0][15:0] LINE_FN_RST = {
        FN_REF_SW, FN_FREE_IN, FN_LIM_NEG, FN_LIM_POS};
    localparam logic [3:0] FREE_OUT_RST = 4'h0;

    // Converter sizes
    localparam int DIV_NW = 78;
    localparam int DIV_DW = 47;

    typedef enum logic [0:0] {
        CV_IDLE = 1'b0,
        CV_WAIT = 1'b1
    } psm_cv_type;

    // Decoded input functions handed to the motion logic
    typedef struct packed {
        logic fault_reset;
        logic enable;
        logic halt;
        logic jog_pos;
        logic jog_neg;
        logic jog_fast;
        logic ref_sw;
        logic positive_limit_switch;
        logic negative_limit_switch;
    } psm_fn_type;

endpackage

/* logic/psm_divider.sv */
// Unsigned restoring divider, one quotient bit per clock.
// Assumes start is a single-cycle pulse while not busy and divisor > 0.
`timescale 1ns/1ps
module psm_divider #(
    parameter int NW = 78,
    parameter int DW = 47
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Request
    input wire logic start_i,
    input wire logic [NW-1:0] dividend_i,
    input wire logic [DW-1:0] divisor_i,
    // Answer
    output logic busy_o,
    output logic done_o,
    output logic [NW-1:0] quotient_o
);
    localparam int CW = $clog2(NW + 1);
    localparam logic [CW-1:0] LAST = CW'(NW - 1);

    typedef struct packed {
        logic [DW-1:0] rem;
        logic [NW-1:0] quo;
        logic [DW-1:0] div;
        logic [CW-1:0] cnt;
        logic busy;
        logic done;
    } psm_div_state_type;

    psm_div_state_type s_r;
    psm_div_state_type s_nxt;
    logic [DW:0] rem_sh;

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        rem_sh = {s_r.rem, s_r.quo[NW-1]};
        if (start_i && !s_r.busy) begin
            s_nxt.rem = '0;
            s_nxt.quo = dividend_i;
            s_nxt.div = divisor_i;
            s_nxt.cnt = '0;
            s_nxt.busy = 1'b1;
        end else if (s_r.busy) begin
            if (rem_sh >= {1'b0, s_r.div}) begin
                s_nxt.rem = DW'(rem_sh - {1'b0, s_r.div});
                s_nxt.quo = {s_r.quo[NW-2:0], 1'b1};
            end else begin
                s_nxt.rem = rem_sh[DW-1:0];
                s_nxt.quo = {s_r.quo[NW-2:0], 1'b0};
            end
            s_nxt.cnt = CW'(s_r.cnt + 1'b1);
            if (s_r.cnt == LAST) begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy_o = s_r.busy;
    assign done_o = s_r.done;
    assign quotient_o = s_r.quo;

endmodule // psm_divider

/* logic/psm_scaling_io.sv */
// Position scaling registers, user/increment converter and line map.
// Assumes a single-cycle parameter port driven synchronously to SYS_CLK_I.
`timescale 1ns/1ps
module psm_scaling_io (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic ARST_N_I,
    // Parameter access
    input wire logic PAR_WR_I,
    input wire logic PAR_RD_I,
    input wire logic [15:0] PAR_ADDR_I,
    input wire logic [31:0] PAR_WDATA_I,
    output logic [31:0] PAR_RDATA_O,
    output logic PAR_ACK_O,
    output logic PAR_ERR_O,
    // Drive state
    input wire logic POWER_STAGE_EN_I,
    input wire logic POWER_ON_I,
    input wire logic FACTORY_RST_I,
    input wire logic NO_FAULT_I,
    input wire logic ACTIVE_I,
    // Position converter
    input wire logic CONV_REQ_I,
    input wire logic CONV_TO_USR_I,
    input wire logic [31:0] CONV_VAL_I,
    output logic [31:0] CONV_RESULT_O,
    output logic CONV_DONE_O,
    output logic CONV_REFUSED_O,
    output logic CONV_BUSY_O,
    // Local lines
    input wire logic [3:0] LINE_IN_I,
    output logic [3:0] LINE_OUT_O,
    output logic [3:0] LINE_OE_O,
    output psm_pkg::psm_fn_type LINE_FN_O
);

    typedef struct packed {
        logic [31:0] num_store;
        logic [31:0] den_store;
        logic [31:0] num_act;
        logic [31:0] den_act;
        logic [3:0][15:0] fn_store;
        logic [3:0][15:0] fn_act;
        logic [3:0] free_out;
        logic ack;
        logic err;
        logic [31:0] rdata;
        psm_pkg::psm_fn_type fn_out;
        logic [3:0] line_out;
        psm_pkg::psm_cv_type cv;
        logic neg;
        logic [31:0] result;
        logic done;
        logic refused;
    } psm_state_type;

    // Function code, input or output, allowed on a given line
    function automatic logic code_ok(input logic [1:0] line,
                                     input logic [15:0] code);
        case (code)
            psm_pkg::FN_LIM_POS: code_ok = (line == 2'h0);
            psm_pkg::FN_LIM_NEG: code_ok = (line == 2'h1);
            psm_pkg::FN_FREE_IN, psm_pkg::FN_FAULT_RESET,
            psm_pkg::FN_ENABLE, psm_pkg::FN_HALT,
            psm_pkg::FN_JOG_POS, psm_pkg::FN_JOG_NEG,
            psm_pkg::FN_JOG_FAST, psm_pkg::FN_REF_SW,
            psm_pkg::FN_OUT_FREE, psm_pkg::FN_OUT_NO_FAULT,
            psm_pkg::FN_OUT_ACTIVE: code_ok = 1'b1;
            default: code_ok = 1'b0;
        endcase
    endfunction

    function automatic logic is_output(input logic [15:0] code);
        is_output = (code == psm_pkg::FN_OUT_FREE) ||
                    (code == psm_pkg::FN_OUT_NO_FAULT) ||
                    (code == psm_pkg::FN_OUT_ACTIVE);
    endfunction

    function automatic logic scale_ok(input logic [31:0] v);
        scale_ok = (v >= psm_pkg::SCALE_MIN) && (v <= psm_pkg::SCALE_MAX);
    endfunction

    logic [1:0] rst_sync_r;
    logic rst_n;
    psm_state_type s_r;
    psm_state_type s_nxt;
    logic div_start;
    logic [psm_pkg::DIV_NW-1:0] div_dividend;
    logic [psm_pkg::DIV_DW-1:0] div_divisor;
    logic div_done;
    logic [psm_pkg::DIV_NW-1:0] div_quo;
    logic [32:0] mag;
    logic [63:0] prod;
    logic fine_scale;
    logic beyond;
    logic hit;
    logic [31:0] limit;
    logic [15:0] fn_addr;
    logic [3:0] free_state;

    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    psm_divider #(
        .NW(psm_pkg::DIV_NW),
        .DW(psm_pkg::DIV_DW)
    ) u_div (
        .clk_i(SYS_CLK_I),
        .rst_n_i(rst_n),
        .start_i(div_start),
        .dividend_i(div_dividend),
        .divisor_i(div_divisor),
        .busy_o(),
        .done_o(div_done),
        .quotient_o(div_quo)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = PAR_WR_I || PAR_RD_I;
        s_nxt.err = 1'b0;
        s_nxt.done = 1'b0;
        s_nxt.refused = 1'b0;
        hit = 1'b0;
        fn_addr = psm_pkg::OFF_LINE_FN_BASE;
        for (int i = 0; i < 4; i++) begin
            free_state[i] = (s_r.fn_act[i] == psm_pkg::FN_FREE_IN) &&
                            LINE_IN_I[i];
        end
        // Parameter writes and reads
        if (PAR_WR_I) begin
            case (PAR_ADDR_I)
                psm_pkg::OFF_SCALE_DEN: begin
                    if (POWER_STAGE_EN_I || !scale_ok(PAR_WDATA_I)) begin
                        s_nxt.err = 1'b1;
                    end else begin
                        s_nxt.den_store = PAR_WDATA_I;
                    end
                end
                psm_pkg::OFF_SCALE_NUM: begin
                    if (POWER_STAGE_EN_I || !scale_ok(PAR_WDATA_I)) begin
                        s_nxt.err = 1'b1;
                    end else begin
                        s_nxt.num_store = PAR_WDATA_I;
                        s_nxt.num_act = PAR_WDATA_I;
                        s_nxt.den_act = s_r.den_store;
                    end
                end
                psm_pkg::OFF_FREE_OUT: s_nxt.free_out = PAR_WDATA_I[3:0];
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (PAR_ADDR_I == fn_addr) begin
                            hit = 1'b1;
                            if (POWER_STAGE_EN_I || PAR_WDATA_I[31:16] != 16'h0
                                || !code_ok(2'(i), PAR_WDATA_I[15:0])) begin
                                s_nxt.err = 1'b1;
                            end else begin
                                s_nxt.fn_store[i] = PAR_WDATA_I[15:0];
                            end
                        end
                        fn_addr = 16'(fn_addr + psm_pkg::OFF_LINE_FN_STEP);
                    end
                    if (!hit) begin
                        s_nxt.err = 1'b1;
                    end
                end
            endcase
        end else if (PAR_RD_I) begin
            s_nxt.rdata = 32'h0;
            case (PAR_ADDR_I)
                psm_pkg::OFF_SCALE_DEN: s_nxt.rdata = s_r.den_store;
                psm_pkg::OFF_SCALE_NUM: s_nxt.rdata = s_r.num_store;
                psm_pkg::OFF_LINE_STATE: s_nxt.rdata = {28'h0, free_state};
                psm_pkg::OFF_FREE_OUT: s_nxt.rdata = {28'h0, s_r.free_out};
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (PAR_ADDR_I == fn_addr) begin
                            hit = 1'b1;
                            s_nxt.rdata = {16'h0, s_r.fn_store[i]};
                        end
                        fn_addr = 16'(fn_addr + psm_pkg::OFF_LINE_FN_STEP);
                    end
                    if (!hit) begin
                        s_nxt.err = 1'b1;
                    end
                end
            endcase
        end
        // Line map takes effect only on a power-on event
        if (POWER_ON_I) begin
            s_nxt.fn_act = s_nxt.fn_store;
        end
        if (FACTORY_RST_I) begin
            s_nxt.num_store = psm_pkg::SCALE_NUM_RST;
            s_nxt.den_store = psm_pkg::SCALE_DEN_RST;
            s_nxt.num_act = psm_pkg::SCALE_NUM_RST;
            s_nxt.den_act = psm_pkg::SCALE_DEN_RST;
            s_nxt.fn_store = psm_pkg::LINE_FN_RST;
        end
        // Decoded input functions and output lines
        s_nxt.fn_out = '0;
        for (int i = 0; i < 4; i++) begin
            case (s_r.fn_act[i])
                psm_pkg::FN_FAULT_RESET: s_nxt.fn_out.fault_reset = LINE_IN_I[i];
                psm_pkg::FN_ENABLE: s_nxt.fn_out.enable = LINE_IN_I[i];
                psm_pkg::FN_HALT: s_nxt.fn_out.halt = LINE_IN_I[i];
                psm_pkg::FN_JOG_POS: s_nxt.fn_out.jog_pos = LINE_IN_I[i];
                psm_pkg::FN_JOG_NEG: s_nxt.fn_out.jog_neg = LINE_IN_I[i];
                psm_pkg::FN_JOG_FAST: s_nxt.fn_out.jog_fast = LINE_IN_I[i];
                psm_pkg::FN_REF_SW: s_nxt.fn_out.ref_sw = LINE_IN_I[i];
                psm_pkg::FN_LIM_POS:
                    s_nxt.fn_out.positive_limit_switch = LINE_IN_I[i];
                psm_pkg::FN_LIM_NEG:
                    s_nxt.fn_out.negative_limit_switch = LINE_IN_I[i];
                default: ;
            endcase
            case (s_r.fn_act[i])
                psm_pkg::FN_OUT_FREE: s_nxt.line_out[i] = s_r.free_out[i];
                psm_pkg::FN_OUT_NO_FAULT: s_nxt.line_out[i] = NO_FAULT_I;
                psm_pkg::FN_OUT_ACTIVE: s_nxt.line_out[i] = ACTIVE_I;
                default: s_nxt.line_out[i] = 1'b0;
            endcase
        end
        // Position converter: magnitude scaled by 2^15 increments per revolution; the quotient truncates toward zero
        mag = CONV_VAL_I[31] ? 33'(33'h0 - {1'b1, CONV_VAL_I})
                             : {1'b0, CONV_VAL_I};
        prod = 64'(mag) * (CONV_TO_USR_I ? 64'(s_r.den_act)
                                         : 64'(s_r.num_act));
        fine_scale = {s_r.num_act[31:0], 15'h0} <
                     {15'h0, s_r.den_act};
        beyond = ($signed(CONV_VAL_I) < $signed(psm_pkg::RANGE_MIN)) ||
                 ($signed(CONV_VAL_I) > $signed(psm_pkg::RANGE_MAX));
        div_start = 1'b0;
        div_dividend = CONV_TO_USR_I ? {14'h0, prod} : {prod[62:0], 15'h0};
        div_divisor = CONV_TO_USR_I ? {s_r.num_act, 15'h0}
                                    : {15'h0, s_r.den_act};
        limit = s_r.neg ? psm_pkg::SAT_NEG : psm_pkg::SAT_POS;
        case (s_r.cv)
            psm_pkg::CV_IDLE: begin
                if (CONV_REQ_I) begin
                    if (!CONV_TO_USR_I && fine_scale && beyond) begin
                        s_nxt.refused = 1'b1;
                    end else begin
                        div_start = 1'b1;
                        s_nxt.neg = CONV_VAL_I[31];
                        s_nxt.cv = psm_pkg::CV_WAIT;
                    end
                end
            end
            psm_pkg::CV_WAIT: begin
                if (div_done) begin
                    // Clip rather than wrap when the result will not fit
                    if (div_quo > {46'h0, limit}) begin
                        s_nxt.result = limit;
                    end else begin
                        s_nxt.result = s_r.neg ? 32'(32'h0 - div_quo[31:0])
                                               : div_quo[31:0];
                    end
                    s_nxt.done = 1'b1;
                    s_nxt.cv = psm_pkg::CV_IDLE;
                end
            end
            default: s_nxt.cv = psm_pkg::CV_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.num_store <= psm_pkg::SCALE_NUM_RST;
            s_r.den_store <= psm_pkg::SCALE_DEN_RST;
            s_r.num_act <= psm_pkg::SCALE_NUM_RST;
            s_r.den_act <= psm_pkg::SCALE_DEN_RST;
            s_r.fn_store <= psm_pkg::LINE_FN_RST;
            s_r.fn_act <= psm_pkg::LINE_FN_RST;
            s_r.free_out <= psm_pkg::FREE_OUT_RST;
            s_r.cv <= psm_pkg::CV_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    generate
        for (genvar g = 0; g < 4; g++) begin : g_line
            assign LINE_OE_O[g] = is_output(s_r.fn_act[g]);
        end
    endgenerate

    assign PAR_RDATA_O = s_r.rdata;
    assign PAR_ACK_O = s_r.ack;
    assign PAR_ERR_O = s_r.err;
    assign CONV_RESULT_O = s_r.result;
    assign CONV_DONE_O = s_r.done;
    assign CONV_REFUSED_O = s_r.refused;
    assign CONV_BUSY_O = (s_r.cv != psm_pkg::CV_IDLE);
    assign LINE_OUT_O = s_r.line_out;
    assign LINE_FN_O = s_r.fn_out;

    chk_num_range: assert property (
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        scale_ok(s_r.num_act) && scale_ok(s_r.den_store))
        else $error("scale value out of range");

    chk_den_pending: assert property (
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        PAR_WR_I && PAR_ADDR_I == psm_pkg::OFF_SCALE_DEN && !FACTORY_RST_I
        |=> $stable(s_r.den_act) && $stable(s_r.num_act))
        else $error("denominator write changed active scale");

    chk_num_activate: assert property (
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        PAR_WR_I && PAR_ADDR_I == psm_pkg::OFF_SCALE_NUM &&
        !POWER_STAGE_EN_I && scale_ok(PAR_WDATA_I) && !FACTORY_RST_I
        |=> s_r.num_act == $past(PAR_WDATA_I) &&
            s_r.den_act == $past(s_r.den_store) && !PAR_ERR_O)
        else $error("numerator write did not activate scaling");

    chk_enabled_lock: assert property (
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        PAR_WR_I && POWER_STAGE_EN_I && !FACTORY_RST_I &&
        PAR_ADDR_I == psm_pkg::OFF_SCALE_NUM
        |=> PAR_ERR_O && $stable(s_r.num_store))
        else $error("scale changed with power stage enabled");

    chk_limit_lines: assert property (
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        s_r.fn_store[1] != psm_pkg::FN_LIM_POS &&
        s_r.fn_store[0] != psm_pkg::FN_LIM_NEG &&
        s_r.fn_store[2] != psm_pkg::FN_LIM_POS &&
        s_r.fn_store[3] != psm_pkg::FN_LIM_NEG)
        else $error("limit function on wrong line");

    chk_fn_power_on: assert property (
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        !POWER_ON_I |=> $stable(s_r.fn_act))
        else $error("line function changed without power-on");

    chk_refuse_fine: assert property (
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        CONV_REQ_I && !CONV_BUSY_O && !CONV_TO_USR_I && !fine_scale
        |=> !CONV_REFUSED_O ##1 CONV_BUSY_O)
        else $error("move refused under coarse scaling");

    chk_conv_bound: assert property (
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        $rose(CONV_BUSY_O) |-> ##[70:90] CONV_DONE_O)
        else $error("conversion did not finish in time");

endmodule // psm_scaling_io

/* sim/psm_field_model.sv */
// Field switches wired to the four local lines.
// Assumes a line driven by the block shows the block's level.
`timescale 1ns/1ps
module psm_field_model (
    // Switch side
    input wire logic [3:0] switch_i,
    // Block side
    input wire logic [3:0] line_out_i,
    input wire logic [3:0] line_oe_i,
    output logic [3:0] line_in_o
);
    // Where both would drive, the block wins so a bad map shows up
    assign line_in_o = (line_oe_i & line_out_i) | (~line_oe_i & switch_i);
endmodule // psm_field_model

/* sim/test_position_scaling_and_io_function_map.sv */
// Self-checking bench for scaling registers, converter and line map.
// Assumes psm_pkg and psm_scaling_io are compiled before this file.
`timescale 1ns/1ps
module test_position_scaling_and_io_function_map;
    logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, pse = 1'b0;
    logic pon = 1'b0, frst = 1'b0, creq = 1'b0, cusr = 1'b0, nf = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wdata = 32'h0, cval = 32'h0, rdata, cres, last_rd;
    logic ack, err, cdone, cref, cbusy;
    logic [3:0] sw = 4'h0, lin, lout, loe;
    psm_pkg::psm_fn_type fn;
    int n_mismatch = 0, n_checks = 0;
    logic [15:0] codes [13] = '{psm_pkg::FN_FREE_IN, psm_pkg::FN_FAULT_RESET,
        psm_pkg::FN_ENABLE, psm_pkg::FN_HALT, psm_pkg::FN_JOG_POS,
        psm_pkg::FN_JOG_NEG, psm_pkg::FN_JOG_FAST, psm_pkg::FN_REF_SW,
        psm_pkg::FN_LIM_POS, psm_pkg::FN_LIM_NEG, psm_pkg::FN_OUT_FREE,
        psm_pkg::FN_OUT_NO_FAULT, psm_pkg::FN_OUT_ACTIVE};

    always #2 clk = ~clk;

    psm_scaling_io dut (.SYS_CLK_I(clk), .ARST_N_I(arst_n), .PAR_WR_I(wr),
        .PAR_RD_I(rd), .PAR_ADDR_I(addr), .PAR_WDATA_I(wdata),
        .PAR_RDATA_O(rdata), .PAR_ACK_O(ack), .PAR_ERR_O(err),
        .POWER_STAGE_EN_I(pse), .POWER_ON_I(pon), .FACTORY_RST_I(frst),
        .NO_FAULT_I(nf), .ACTIVE_I(1'b0), .CONV_REQ_I(creq),
        .CONV_TO_USR_I(cusr), .CONV_VAL_I(cval), .CONV_RESULT_O(cres),
        .CONV_DONE_O(cdone), .CONV_REFUSED_O(cref), .CONV_BUSY_O(cbusy),
        .LINE_IN_I(lin), .LINE_OUT_O(lout), .LINE_OE_O(loe),
        .LINE_FN_O(fn));

    psm_field_model field (.switch_i(sw), .line_out_i(lout),
        .line_oe_i(loe), .line_in_o(lin));

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One word access; answer is looked at in its single cycle
    task automatic access(input logic w, input logic [15:0] a,
                          input logic [31:0] d, input logic e);
        @(negedge clk);
        wr = w;
        rd = ~w;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
        check("ack", {31'h0, ack}, 32'h1);
        check("err", {31'h0, err}, {31'h0, e});
        last_rd = rdata;
    endtask

    task automatic conv(input logic u, input logic [31:0] v,
                        input logic exp_ref, input logic [31:0] exp_res);
        @(negedge clk);
        creq = 1'b1;
        cusr = u;
        cval = v;
        @(negedge clk);
        creq = 1'b0;
        check("refused", {31'h0, cref}, {31'h0, exp_ref});
        if (!exp_ref) begin
            for (int i = 0; i < 100 && cdone !== 1'b1; i++) begin
                @(negedge clk);
            end
            check("done", {31'h0, cdone}, 32'h1);
            check("result", cres, exp_res);
        end
    endtask

    task automatic t_factory();
        access(1'b0, psm_pkg::OFF_SCALE_NUM, 32'h0, 1'b0);
        check("numerator", last_rd, 32'h0000_0001);
        access(1'b0, psm_pkg::OFF_SCALE_DEN, 32'h0, 1'b0);
        check("denominator", last_rd, 32'h0000_4000);
        for (int i = 0; i < 4; i++) begin
            access(1'b0, 16'h0722 + 16'(2 * i), 32'h0, 1'b0);
            check("line map", last_rd, {16'h0, psm_pkg::LINE_FN_RST[i]});
        end
        conv(1'b0, 32'h0000_0064, 1'b0, 32'h0000_00c8);
        conv(1'b0, 32'hffff_fffd, 1'b0, 32'hffff_fffa);
        conv(1'b1, 32'h0000_00c8, 1'b0, 32'h0000_0064);
    endtask

    task automatic t_scale_writes();
        pse = 1'b1;
        access(1'b1, psm_pkg::OFF_SCALE_NUM, 32'h2, 1'b1);
        pse = 1'b0;
        access(1'b1, psm_pkg::OFF_SCALE_NUM, 32'h0, 1'b1);
        access(1'b1, psm_pkg::OFF_SCALE_DEN, 32'h8000_0000, 1'b1);
        access(1'b0, psm_pkg::OFF_SCALE_NUM, 32'h0, 1'b0);
        check("kept numerator", last_rd, 32'h0000_0001);
        access(1'b1, psm_pkg::OFF_SCALE_DEN, 32'h1, 1'b0);
        conv(1'b0, 32'h1, 1'b0, 32'h2);
        access(1'b1, psm_pkg::OFF_SCALE_NUM, 32'h1, 1'b0);
        conv(1'b0, 32'h1, 1'b0, 32'h0000_8000);
        // Master restates a jog step of one revolution in the new units
        conv(1'b1, 32'h0000_8000, 1'b0, 32'h1);
        access(1'b1, psm_pkg::OFF_SCALE_DEN, 32'h7fff_ffff, 1'b0);
        access(1'b1, psm_pkg::OFF_SCALE_NUM, 32'h1, 1'b0);
        conv(1'b0, 32'h4000_0000, 1'b1, 32'h0);
        conv(1'b0, 32'h1, 1'b0, 32'h0);
        conv(1'b1, 32'h7fff_ffff, 1'b0, 32'h7fff_ffff);
        @(negedge clk);
        frst = 1'b1;
        @(negedge clk);
        frst = 1'b0;
        access(1'b0, psm_pkg::OFF_SCALE_DEN, 32'h0, 1'b0);
        check("restored denominator", last_rd, 32'h0000_4000);
    endtask

    task automatic t_lines();
        foreach (codes[i]) begin
            access(1'b1, 16'h0726, {16'h0, codes[i]},
                   codes[i] == psm_pkg::FN_LIM_POS ||
                   codes[i] == psm_pkg::FN_LIM_NEG);
        end
        access(1'b1, 16'h0726, {16'h0, psm_pkg::FN_FREE_IN}, 1'b0);
        access(1'b1, 16'h0724, 32'h5, 1'b1);
        access(1'b1, 16'h0724, {16'h0, psm_pkg::FN_LIM_POS}, 1'b1);
        pse = 1'b1;
        access(1'b1, 16'h0722, 32'h1, 1'b1);
        pse = 1'b0;
        access(1'b1, 16'h0722, 32'h1, 1'b0);
        sw = 4'hf;
        access(1'b0, psm_pkg::OFF_LINE_STATE, 32'h0, 1'b0);
        check("state before", last_rd, 32'h4);
        check("limit before", {31'h0, fn.positive_limit_switch}, 32'h1);
        @(negedge clk);
        pon = 1'b1;
        @(negedge clk);
        pon = 1'b0;
        access(1'b0, psm_pkg::OFF_LINE_STATE, 32'h0, 1'b0);
        check("state after", last_rd, 32'h5);
        check("limit after", {31'h0, fn.positive_limit_switch}, 32'h0);
        check("neg limit", {31'h0, fn.negative_limit_switch}, 32'h1);
        check("ref switch", {31'h0, fn.ref_sw}, 32'h1);
    endtask

    task automatic t_outputs();
        access(1'b1, 16'h0726, 32'h0000_0065, 1'b0);
        access(1'b1, 16'h0724, 32'h0000_0066, 1'b0);
        access(1'b1, 16'h0728, 32'h0000_0004, 1'b0);
        access(1'b1, psm_pkg::OFF_LINE_STATE, 32'h0, 1'b1);
        access(1'b1, psm_pkg::OFF_FREE_OUT, 32'h4, 1'b0);
        access(1'b0, psm_pkg::OFF_FREE_OUT, 32'h0, 1'b0);
        check("free out", last_rd, 32'h4);
        nf = 1'b1;
        @(negedge clk);
        pon = 1'b1;
        @(negedge clk);
        pon = 1'b0;
        access(1'b0, psm_pkg::OFF_LINE_STATE, 32'h0, 1'b0);
        check("state outputs", last_rd, 32'h1);
        check("line oe", {28'h0, loe}, 32'h6);
        check("line out", {28'h0, lout}, 32'h6);
        check("halt", {31'h0, fn.halt}, 32'h1);
        check("ref off", {31'h0, fn.ref_sw}, 32'h0);
        // Reset in mid-run brings back the factory map
        @(negedge clk);
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        check("oe after reset", {28'h0, loe}, 32'h0);
        access(1'b0, 16'h0724, 32'h0, 1'b0);
        check("map after reset", last_rd, 32'h0000_0016);
    endtask

    initial begin
        #10000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_factory();
        t_scale_writes();
        t_lines();
        t_outputs();
        print_verdict();
    end
endmodule // test_position_scaling_and_io_function_map
